// ### rtl/ises_pkg.sv
// constants for the instrument status and event register block
package ises_pkg;
    // standard event register bit positions
    localparam int SE_POWER_ON = 7;
    localparam int SE_SYNTAX = 5;
    localparam int SE_EXEC = 4;
    localparam int SE_DEVICE = 3;
    localparam int SE_QUERY = 2;
    localparam int SE_DONE = 0;
    // operation register bit positions
    localparam int OP_FULL3 = 10;
    localparam int OP_FULL2 = 9;
    localparam int OP_FULL1 = 8;
    localparam int OP_CORRECT = 7;
    localparam int OP_TRIG_WAIT = 5;
    localparam int OP_MEASURE = 4;
    localparam int OP_ACQUIRE = 3;
    localparam int OP_RANGE = 2;
    localparam int OP_SETTLE = 1;
    // implemented-bit masks; other flag, condition and event bits read zero
    localparam logic [7:0] SE_USED = 8'hBD;
    localparam logic [15:0] OP_USED = 16'h07BE;
    // power-up values
    localparam logic [7:0] SE_POWERUP = 8'h80;
    localparam logic [7:0] SE_MASK_RST = 8'h00;
    localparam logic [15:0] OP_RST = 16'h0000;
    // register select codes for the host access port
    localparam logic [2:0] SEL_SE_FLAGS = 3'h0;
    localparam logic [2:0] SEL_SE_MASK = 3'h1;
    localparam logic [2:0] SEL_OP_COND = 3'h2;
    localparam logic [2:0] SEL_OP_EVENT = 3'h3;
    localparam logic [2:0] SEL_OP_MASK = 3'h4;
endpackage

// ### rtl/ises_status_regs.sv
// status and event register bank of the remote interface
`timescale 1ns/1ps
`default_nettype none
// Behaviour
// - standard summary high when any flag bit and its mask bit are both one
// - power-on flag set at power-up, stays zero after a read clears it
// - syntax error in a program message sets flag bit 5
// - out-of-range or contradictory settings set flag bit 4
// - error queue overflow sets flag bit 3
// - read of empty output buffer or lost response sets bit 2
// - completion of commands up to the completion command sets bit 0
// - reading standard flags returns them then clears; clear command clears
// - power-up clears standard flags except power-on flag set
// - standard mask read/write, cleared only by writing zero or power-up
// - values are sums of weights of set bits; host encodes alike
// - condition changes latch into events; operation summary from masked events
// - bits 8-10 buffer full, bit 7 correction; events on full and completion
// - bit 5 trigger waiting; event latched on entering wait
// - bit 4 measuring mirrors end-of-measure; event on measurement end
// - bit 3 acquiring mirrors index output; event on acquisition end
// - bit 2 range switching; event when range is established
// - bit 1 settling during trigger delay; event when delay ends
// - unused flag, condition and event bits always read zero; the operation mask keeps all 16 written bits, the standard mask bits 7-0
// - reading the condition register returns live status, clears nothing
// - reading operation events clears them; clear command and power-up too
// - operation mask read/write, cleared only by writing zero or power-up
module ises_status_regs (
    input wire logic sys_clk,
    input wire logic rst,
    // one-cycle event pulses from the command parser
    input wire logic syntax_error_flag,
    input wire logic execution_error_flag,
    input wire logic device_error_flag,
    input wire logic query_error_flag,
    input wire logic op_complete_flag,
    input wire logic clear_status,
    // live device status levels, from other clock domains or pins
    input wire logic first_buffer_full,
    input wire logic second_buffer_full,
    input wire logic third_buffer_full,
    input wire logic correction_running,
    input wire logic trigger_waiting,
    input wire logic handler_end_of_measure,
    input wire logic handler_index,
    input wire logic range_switching,
    input wire logic signal_settling,
    // host register access port
    input wire logic [2:0] reg_sel,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [15:0] reg_wdata,
    output logic [15:0] reg_rdata,
    output logic reg_rvalid,
    output logic std_event_summary,
    output logic operation_summary
);
    localparam int NCOND = 9;

    logic [NCOND-1:0] cond_raw;
    logic [NCOND-1:0] sync1_r;
    logic [NCOND-1:0] sync2_r;
    logic [NCOND-1:0] sync3_r;
    logic [NCOND-1:0] stable_r;
    logic [15:0] op_condition_live;
    logic [15:0] fall_evt;
    logic [7:0] std_event_flags_r;
    logic [7:0] std_event_flags_nxt;
    logic [7:0] std_event_mask_r;
    logic [15:0] op_event_latched_r;
    logic [15:0] op_event_latched_nxt;
    logic [15:0] op_event_mask_r;
    logic [7:0] se_set;
    logic rd_se;
    logic rd_op;

    // order of the status inputs inside the synchroniser vector
    assign cond_raw = {third_buffer_full, second_buffer_full,
        first_buffer_full, correction_running, trigger_waiting,
        handler_end_of_measure, handler_index, range_switching,
        signal_settling};

    // three-stage sync; a change is accepted once stages two and three agree
    genvar gi;
    generate
        for (gi = 0; gi < NCOND; gi = gi + 1) begin : g_sync
            always_ff @(posedge sys_clk) begin
                if (rst) begin
                    sync1_r[gi] <= 1'b0;
                    sync2_r[gi] <= 1'b0;
                    sync3_r[gi] <= 1'b0;
                    stable_r[gi] <= 1'b0;
                end else begin
                    sync1_r[gi] <= cond_raw[gi];
                    sync2_r[gi] <= sync1_r[gi];
                    sync3_r[gi] <= sync2_r[gi];
                    if (sync2_r[gi] == sync3_r[gi]) begin
                        stable_r[gi] <= sync3_r[gi];
                    end
                end
            end
        end
    endgenerate

    // live condition word; unused positions tied low
    always_comb begin
        op_condition_live = ises_pkg::OP_RST;
        op_condition_live[ises_pkg::OP_SETTLE] = stable_r[0];
        op_condition_live[ises_pkg::OP_RANGE] = stable_r[1];
        op_condition_live[ises_pkg::OP_ACQUIRE] = stable_r[2];
        op_condition_live[ises_pkg::OP_MEASURE] = stable_r[3];
        op_condition_live[ises_pkg::OP_TRIG_WAIT] = stable_r[4];
        op_condition_live[ises_pkg::OP_CORRECT] = stable_r[5];
        op_condition_live[ises_pkg::OP_FULL1] = stable_r[6];
        op_condition_live[ises_pkg::OP_FULL2] = stable_r[7];
        op_condition_live[ises_pkg::OP_FULL3] = stable_r[8];
    end

    // previous condition to see edges; reset shares with the stable stage
    logic [15:0] cond_prev_r;
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            cond_prev_r <= ises_pkg::OP_RST;
        end else begin
            cond_prev_r <= op_condition_live;
        end
    end

    // fixed filter: buffers and trigger wait fire on rise, rest on fall
    always_comb begin
        fall_evt = cond_prev_r & ~op_condition_live;
        fall_evt[ises_pkg::OP_FULL1] =
            op_condition_live[ises_pkg::OP_FULL1]
            & ~cond_prev_r[ises_pkg::OP_FULL1];
        fall_evt[ises_pkg::OP_FULL2] =
            op_condition_live[ises_pkg::OP_FULL2]
            & ~cond_prev_r[ises_pkg::OP_FULL2];
        fall_evt[ises_pkg::OP_FULL3] =
            op_condition_live[ises_pkg::OP_FULL3]
            & ~cond_prev_r[ises_pkg::OP_FULL3];
        fall_evt[ises_pkg::OP_TRIG_WAIT] =
            op_condition_live[ises_pkg::OP_TRIG_WAIT]
            & ~cond_prev_r[ises_pkg::OP_TRIG_WAIT];
        fall_evt = fall_evt & ises_pkg::OP_USED;
    end

    // read strobes that clear their register
    assign rd_se = reg_rd && (reg_sel == ises_pkg::SEL_SE_FLAGS);
    assign rd_op = reg_rd && (reg_sel == ises_pkg::SEL_OP_EVENT);

    // incoming standard events
    always_comb begin
        se_set = 8'h00;
        se_set[ises_pkg::SE_SYNTAX] = syntax_error_flag;
        se_set[ises_pkg::SE_EXEC] = execution_error_flag;
        se_set[ises_pkg::SE_DEVICE] = device_error_flag;
        se_set[ises_pkg::SE_QUERY] = query_error_flag;
        se_set[ises_pkg::SE_DONE] = op_complete_flag;
    end

    // clear by read or clear command, then a same-cycle set wins
    always_comb begin
        std_event_flags_nxt = std_event_flags_r;
        if (rd_se || clear_status) begin
            std_event_flags_nxt = 8'h00;
        end
        std_event_flags_nxt = (std_event_flags_nxt | se_set)
            & ises_pkg::SE_USED;
    end

    // power-up leaves only the power-on flag
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            std_event_flags_r <= ises_pkg::SE_POWERUP;
        end else begin
            std_event_flags_r <= std_event_flags_nxt;
        end
    end

    // operation events: read or clear command empties, new events win
    always_comb begin
        op_event_latched_nxt = op_event_latched_r;
        if (rd_op || clear_status) begin
            op_event_latched_nxt = ises_pkg::OP_RST;
        end
        op_event_latched_nxt = op_event_latched_nxt | fall_evt;
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            op_event_latched_r <= ises_pkg::OP_RST;
        end else begin
            op_event_latched_r <= op_event_latched_nxt;
        end
    end

    // masks: only a host write or power-up changes them; clear_status does not
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            std_event_mask_r <= ises_pkg::SE_MASK_RST;
            op_event_mask_r <= ises_pkg::OP_RST;
        end else if (reg_wr) begin
            if (reg_sel == ises_pkg::SEL_SE_MASK) begin
                std_event_mask_r <= reg_wdata[7:0];
            end
            if (reg_sel == ises_pkg::SEL_OP_MASK) begin
                op_event_mask_r <= reg_wdata;
            end
        end
    end

    // summaries registered from next-state so outputs come from flops
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            std_event_summary <= 1'b0;
            operation_summary <= 1'b0;
        end else begin
            std_event_summary <= |(std_event_flags_nxt
                & std_event_mask_r);
            operation_summary <= |(op_event_latched_nxt
                & op_event_mask_r);
        end
    end

    // read data: weight-sum binary value, valid one cycle after read
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            reg_rdata <= 16'h0000;
            reg_rvalid <= 1'b0;
        end else begin
            reg_rvalid <= reg_rd;
            if (reg_rd) begin
                case (reg_sel)
                    ises_pkg::SEL_SE_FLAGS:
                        reg_rdata <= {8'h00, std_event_flags_r};
                    ises_pkg::SEL_SE_MASK:
                        reg_rdata <= {8'h00, std_event_mask_r};
                    ises_pkg::SEL_OP_COND:
                        reg_rdata <= op_condition_live;
                    ises_pkg::SEL_OP_EVENT:
                        reg_rdata <= op_event_latched_r;
                    ises_pkg::SEL_OP_MASK:
                        reg_rdata <= op_event_mask_r;
                    default:
                        reg_rdata <= 16'h0000;
                endcase
            end
        end
    end
endmodule
`default_nettype wire

// ### test/ises_host_model.sv
// host controller model driving status commands and queries
`timescale 1ns/1ps
`default_nettype none
module ises_host_model (
    input wire logic sys_clk,
    input wire logic [15:0] reg_rdata,
    output logic [2:0] reg_sel,
    output logic reg_wr,
    output logic reg_rd,
    output logic [15:0] reg_wdata
);
    initial begin
        reg_sel = 3'h0;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        reg_wdata = 16'h0000;
    end
    // optional write, then n back-to-back reads; drives on falling edges
    task automatic xfer(input logic [2:0] s, input logic w,
        input logic [15:0] v, input int n,
        output logic [15:0] g0, output logic [15:0] g1);
        @(negedge sys_clk);
        reg_sel <= s;
        reg_wr <= w;
        reg_wdata <= v;
        reg_rd <= !w && n > 0;
        if (w) begin
            @(negedge sys_clk);
            reg_wr <= 1'b0;
            reg_wdata <= ~v; // released data shows no stale value
            reg_rd <= n > 0;
        end
        for (int i = 0; i < n; i++) begin
            @(negedge sys_clk);
            if (i == 0) g0 = reg_rdata;
            else g1 = reg_rdata;
            if (i == n - 1) reg_rd <= 1'b0;
        end
    endtask
endmodule
`default_nettype wire

// ### test/ises_status_asserts.sv
// port-level assertions for the status register bank
`timescale 1ns/1ps
`default_nettype none
module ises_status_asserts (
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic syntax_error_flag,
    input wire logic execution_error_flag,
    input wire logic device_error_flag,
    input wire logic query_error_flag,
    input wire logic op_complete_flag,
    input wire logic [2:0] reg_sel,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [15:0] reg_wdata,
    input wire logic [15:0] reg_rdata,
    input wire logic reg_rvalid,
    input wire logic std_event_summary,
    input wire logic operation_summary
);
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (rst);
    logic pulse_any;
    // a same-edge event survives a read-clear, so such cycles are excused
    assign pulse_any = syntax_error_flag | execution_error_flag |
        device_error_flag | query_error_flag | op_complete_flag;
    rd_answer_a: assert property (reg_rd |=> reg_rvalid)
        else $error("read not answered next cycle");
    no_stray_a: assert property (!reg_rd |=> !reg_rvalid)
        else $error("answer without read");
    rdata_hold_a: assert property (!reg_rd |=> $stable(reg_rdata))
        else $error("read data moved without read");
    std_unused_a: assert property (
        reg_rd && reg_sel == ises_pkg::SEL_SE_FLAGS |=>
        (reg_rdata & ~{8'h00, ises_pkg::SE_USED}) == 16'h0000)
        else $error("unused standard bit read one");
    op_unused_a: assert property (
        reg_rd && (reg_sel == ises_pkg::SEL_OP_COND ||
        reg_sel == ises_pkg::SEL_OP_EVENT) |=>
        (reg_rdata & ~ises_pkg::OP_USED) == 16'h0000)
        else $error("unused operation bit read one");
    flags_clear_a: assert property (
        reg_rd && reg_sel == ises_pkg::SEL_SE_FLAGS && !pulse_any ##1
        reg_rd && reg_sel == ises_pkg::SEL_SE_FLAGS |=> reg_rdata == 16'h0000)
        else $error("flags not cleared by read");
    sum_clear_a: assert property (
        reg_rd && reg_sel == ises_pkg::SEL_SE_FLAGS && !pulse_any |=>
        !std_event_summary) else $error("summary stays after read-clear");
    mask_back_a: assert property (
        reg_wr && reg_sel == ises_pkg::SEL_SE_MASK ##1
        reg_rd && reg_sel == ises_pkg::SEL_SE_MASK |=>
        reg_rdata == {8'h00, $past(reg_wdata[7:0], 2)})
        else $error("standard mask readback differs");
    std_off_a: assert property (
        reg_wr && reg_sel == ises_pkg::SEL_SE_MASK &&
        reg_wdata[7:0] == 8'h00 |=> (!reg_wr |=> !std_event_summary))
        else $error("summary with zero mask");
    op_off_a: assert property (
        reg_wr && reg_sel == ises_pkg::SEL_OP_MASK &&
        reg_wdata == 16'h0000 |=> (!reg_wr |=> !operation_summary))
        else $error("operation summary with zero mask");
endmodule
`default_nettype wire

// ### test/tb_ises_status_regs.sv
// self-checking bench for the status register bank
`timescale 1ns/1ps
`default_nettype none
module tb_ises_status_regs;
    logic sys_clk = 1'b0;
    logic rst = 1'b1;
    logic [4:0] ev = 5'h00; // syntax, execution, device, query, complete
    logic clr = 1'b0;
    logic [8:0] cond = 9'h000; // condition inputs in port order
    logic [2:0] reg_sel;
    logic reg_wr, reg_rd, reg_rvalid, std_sum, op_sum;
    logic [15:0] reg_wdata, reg_rdata, g0, g1, w;
    logic up;
    int fails = 0;
    int samples_checked = 0;
    int cycles = 0;
    int pos [9] = '{8, 9, 10, 7, 5, 4, 3, 2, 1};
    ises_status_regs ises_status_regs_inst (.sys_clk(sys_clk), .rst(rst),
        .syntax_error_flag(ev[0]), .execution_error_flag(ev[1]),
        .device_error_flag(ev[2]), .query_error_flag(ev[3]),
        .op_complete_flag(ev[4]), .clear_status(clr),
        .first_buffer_full(cond[0]), .second_buffer_full(cond[1]),
        .third_buffer_full(cond[2]), .correction_running(cond[3]),
        .trigger_waiting(cond[4]), .handler_end_of_measure(cond[5]),
        .handler_index(cond[6]), .range_switching(cond[7]),
        .signal_settling(cond[8]), .reg_sel(reg_sel), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
        .reg_rvalid(reg_rvalid), .std_event_summary(std_sum),
        .operation_summary(op_sum));
    ises_host_model host_inst (.sys_clk(sys_clk), .reg_rdata(reg_rdata),
        .reg_sel(reg_sel), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_wdata(reg_wdata));
    initial begin
        forever #50 sys_clk = ~sys_clk;
    end
    task automatic complete_run();
        $display("compared %0d wrong %0d", samples_checked, fails);
        if (fails == 0 && samples_checked > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask
    // hang guard; the tests need well under a thousand cycles
    always @(posedge sys_clk) begin
        cycles <= cycles + 1;
        if (cycles == 4000) begin
            fails++;
            complete_run();
        end
    end
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        samples_checked++;
        if (got !== exp) begin
            fails++;
            $display("wrong value at %0t: got %h want %h", $time, got, exp);
        end
    endtask
    task automatic rd(input logic [2:0] s, input logic [15:0] exp);
        logic [15:0] a, b;
        host_inst.xfer(s, 1'b0, 16'h0000, 1, a, b);
        chk(a, exp);
    endtask
    // one-cycle pulse, with a gap so calls never collide
    task automatic pulse(input int i);
        @(negedge sys_clk);
        if (i < 5) ev[i] <= 1'b1;
        else clr <= 1'b1;
        @(negedge sys_clk);
        ev <= 5'h00;
        clr <= 1'b0;
    endtask
    initial begin
        repeat (16) @(negedge sys_clk);
        rst <= 1'b0;
        host_inst.xfer(ises_pkg::SEL_SE_FLAGS, 1'b0, 16'h0000, 2, g0, g1);
        chk(g0, 16'h0080);
        chk(g1, 16'h0000);
        for (int s = 1; s < 8; s++) rd(3'(s), 16'h0000);
        $display("reset values done");
        host_inst.xfer(ises_pkg::SEL_SE_MASK, 1'b1, 16'h0000, 0, g0, g1);
        for (int i = 0; i < 5; i++) pulse(i);
        chk({15'h0000, std_sum}, 16'h0000);
        host_inst.xfer(ises_pkg::SEL_SE_MASK, 1'b1, 16'h0020, 1, g0, g1);
        chk(g0, 16'h0020);
        chk({15'h0000, std_sum}, 16'h0001);
        rd(ises_pkg::SEL_SE_FLAGS, 16'h003D);
        pulse(0);
        pulse(5);
        rd(ises_pkg::SEL_SE_FLAGS, 16'h0000);
        rd(ises_pkg::SEL_SE_MASK, 16'h0020);
        $display("standard events done");
        host_inst.xfer(ises_pkg::SEL_OP_MASK, 1'b1, 16'h07BE, 1, g0, g1);
        chk(g0, 16'h07BE);
        for (int i = 0; i < 9; i++) begin
            w = 16'h0001 << pos[i];
            up = (i < 3) || (i == 4); // buffers and trigger wait latch on rise
            @(negedge sys_clk);
            cond[i] <= 1'b1;
            repeat (8) @(negedge sys_clk);
            chk({15'h0000, op_sum}, {15'h0000, up});
            host_inst.xfer(ises_pkg::SEL_OP_COND, 1'b0, 16'h0000, 2, g0, g1);
            chk(g0, w);
            chk(g1, w);
            rd(ises_pkg::SEL_OP_EVENT, up ? w : 16'h0000);
            cond[i] <= 1'b0;
            repeat (8) @(negedge sys_clk);
            rd(ises_pkg::SEL_OP_EVENT, up ? 16'h0000 : w);
        end
        cond[0] <= 1'b1;
        repeat (8) @(negedge sys_clk);
        pulse(5);
        rd(ises_pkg::SEL_OP_EVENT, 16'h0000);
        rd(ises_pkg::SEL_OP_MASK, 16'h07BE);
        cond[1] <= 1'b1;
        repeat (8) @(negedge sys_clk);
        chk({15'h0000, op_sum}, 16'h0001);
        host_inst.xfer(ises_pkg::SEL_OP_MASK, 1'b1, 16'h0000, 1, g0, g1);
        chk(g0, 16'h0000);
        @(negedge sys_clk);
        chk({15'h0000, op_sum}, 16'h0000);
        $display("operation events done");
        complete_run();
    end
endmodule
bind ises_status_regs ises_status_asserts ises_status_asserts_inst (
    .sys_clk(sys_clk), .rst(rst), .syntax_error_flag(syntax_error_flag),
    .execution_error_flag(execution_error_flag),
    .device_error_flag(device_error_flag),
    .query_error_flag(query_error_flag), .op_complete_flag(op_complete_flag),
    .reg_sel(reg_sel), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
    .std_event_summary(std_event_summary),
    .operation_summary(operation_summary));
`default_nettype wire
